// >>> rbpc_consts.vh
// Constants for the registered buffer with parity check: widths, parity masks, reset values.
// Assumes it is included by bare name into each design file that needs it.
`ifndef RBPC_CONSTS_VH
`define RBPC_CONSTS_VH

`define RBPC_WIDE_BITS 25
`define RBPC_NARROW_BITS 14

// Bit i of a mask stands for data input number i+1.
`define RBPC_MASK_WIDE 25'h1ff_ffb6
`define RBPC_MASK_SIDE_A 25'h000_3fb6
`define RBPC_MASK_SIDE_B 25'h000_1bbf

`define RBPC_PAR_LAG_A 1
`define RBPC_PAR_LAG_B 2
`define RBPC_ERR_HOLD_CYC 2

`define RBPC_OUT_RST 1'b0
`define RBPC_ERR_N_RST 1'b1
`define RBPC_SYNC_RST 1'b0

`endif

// >>> rbpc_buf2.v
// Small word buffer with valid and ready on both sides, storage in flip-flops.
// Assumes one clock and an active-high reset that may arrive at any time.
`timescale 1ns/1ps
module rbpc_buf2 #(
  parameter W = 29,
  parameter DEPTH = 2,
  parameter AW = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o,
  output wire full_o,
  output wire empty_o
);
  reg [W-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire pop;
  integer i;

  assign full_o = (count_ff == DEPTH[AW:0]);
  assign empty_o = (count_ff == {(AW+1){1'b0}});
  assign in_ready_o = ~full_o;
  assign out_valid_o = ~empty_o;
  assign out_data_o = mem_ff[rd_ptr_ff];
  assign push = in_valid_i & ~full_o;
  assign pop = out_ready_i & ~empty_o;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_ff[i] <= {W{1'b0}};
      end
    end else begin
      if (push) begin
        mem_ff[wr_ptr_ff] <= in_data_i;
        wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      end
      if (push & ~pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop & ~push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

// >>> rbpc_top.v
// Registered address and command buffer with even-parity check and error latch.
// Assumes pins arrive unsynchronised and the load side drains words with out_ready_i.
`timescale 1ns/1ps
`include "rbpc_consts.vh"
module rbpc_top #(
  parameter DW = `RBPC_WIDE_BITS,
  parameter NW = `RBPC_NARROW_BITS,
  parameter BUF_DEPTH = 2
) (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire config_sel_ab_i,
  input wire config_sel_width_i,
  input wire [DW-1:0] data_in_i,
  input wire dimm_chip_select_n_i,
  input wire chip_select_aux_n_i,
  input wire clk_enable_in_i,
  input wire termination_in_i,
  input wire parity_in_i,
  input wire in_valid_i,
  input wire out_ready_i,
  output reg [DW-1:0] data_out_o,
  output reg [NW-1:0] data_out_b_o,
  output reg chip_select_out_n_o,
  output reg chip_select_out_b_n_o,
  output reg clk_enable_out_o,
  output reg clk_enable_out_b_o,
  output reg termination_out_o,
  output reg termination_out_b_o,
  output reg partial_parity_out_o,
  output reg parity_error_n_o,
  output reg parity_error_oe_o,
  output reg in_ready_o,
  output reg out_valid_o
);
  // Packed pin word: data, four module-dependent bits, parity, valid, two selects.
  localparam PW = DW + 8;
  localparam P_CS = DW;
  localparam P_AUX = DW + 1;
  localparam P_CKE = DW + 2;
  localparam P_ODT = DW + 3;
  localparam P_PAR = DW + 4;
  localparam P_VLD = DW + 5;
  localparam P_AB = DW + 6;
  localparam P_WID = DW + 7;

  // Buffered word: data, chip select, clock enable, termination, gate flag.
  localparam BW = DW + 4;
  localparam integer HOLD_CYC = `RBPC_ERR_HOLD_CYC - 1;
  localparam [1:0] HOLD_LAST = HOLD_CYC[1:0];

  // Chooses the parity-checked data bits for the strapped configuration.
  function [DW-1:0] chk_mask;
    input sel_ab;
    input sel_width;
    begin
      if (!sel_width) begin
        chk_mask = `RBPC_MASK_WIDE;
      end else if (!sel_ab) begin
        chk_mask = `RBPC_MASK_SIDE_A;
      end else begin
        chk_mask = `RBPC_MASK_SIDE_B;
      end
    end
  endfunction

  // Odd-ones result of the checked bits together with the parity bit.
  function odd_sum;
    input [DW-1:0] data;
    input [DW-1:0] mask;
    input par;
    begin
      odd_sum = (^(data & mask)) ^ par;
    end
  endfunction

  wire [PW-1:0] pin_word;
  reg [PW-1:0] sync1_ff;
  reg [PW-1:0] sync2_ff;

  assign pin_word = {config_sel_width_i, config_sel_ab_i, in_valid_i, parity_in_i,
    termination_in_i, clk_enable_in_i, chip_select_aux_n_i, dimm_chip_select_n_i, data_in_i};

  // Two-stage capture of every pin except out_ready_i, core_clk_i and sys_rst_i; later logic reads those pins from the second stage only.
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_ff <= {PW{`RBPC_SYNC_RST}};
      sync2_ff <= {PW{`RBPC_SYNC_RST}};
    end else begin
      sync1_ff <= pin_word;
      sync2_ff <= sync1_ff;
    end
  end

  wire [DW-1:0] cap_data;
  wire cap_cs_n;
  wire cap_aux_n;
  wire cap_cke;
  wire cap_odt;
  wire cap_par;
  wire cap_valid;
  wire cap_ab;
  wire cap_width;
  wire cap_gate;

  assign cap_data = sync2_ff[DW-1:0];
  assign cap_cs_n = sync2_ff[P_CS];
  assign cap_aux_n = sync2_ff[P_AUX];
  assign cap_cke = sync2_ff[P_CKE];
  assign cap_odt = sync2_ff[P_ODT];
  assign cap_par = sync2_ff[P_PAR];
  assign cap_valid = sync2_ff[P_VLD];
  assign cap_ab = sync2_ff[P_AB];
  assign cap_width = sync2_ff[P_WID];
  // Both selects high suspend the data and parity outputs.
  assign cap_gate = cap_cs_n & cap_aux_n;

  // Parity path: data is delayed so that it meets its late parity bit.
  reg [DW-1:0] data_d1_ff;
  reg [DW-1:0] data_d2_ff;
  reg gate_d1_ff;
  reg gate_d2_ff;
  reg odd_stage_ff;
  reg gate_stage_ff;
  reg [1:0] hold_cnt_ff;
  reg [1:0] nxt_hold_cnt;
  reg nxt_err_n;
  reg nxt_ppo;
  wire [DW-1:0] cur_mask;
  wire [DW-1:0] aligned_data;
  wire aligned_gate;
  wire odd_now;

  assign cur_mask = chk_mask(cap_ab, cap_width);
  // Side B sees its parity one cycle later, as the cascade adds a stage.
  assign aligned_data = cap_ab ? data_d2_ff : data_d1_ff;
  assign aligned_gate = cap_ab ? gate_d2_ff : gate_d1_ff;
  // Only masked data bits and the parity bit enter the sum; selects, enable and termination stay out.
  assign odd_now = odd_sum(aligned_data, cur_mask, cap_par);

  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_d1_ff <= {DW{1'b0}};
      data_d2_ff <= {DW{1'b0}};
      gate_d1_ff <= 1'b0;
      gate_d2_ff <= 1'b0;
      odd_stage_ff <= 1'b0;
      gate_stage_ff <= 1'b0;
    end else begin
      data_d1_ff <= cap_data;
      data_d2_ff <= data_d1_ff;
      gate_d1_ff <= cap_gate;
      gate_d2_ff <= gate_d1_ff;
      odd_stage_ff <= odd_now;
      gate_stage_ff <= aligned_gate;
    end
  end

  // Error flag and partial parity; a fresh error is held low for the hold time.
  always @* begin
    nxt_ppo = partial_parity_out_o;
    nxt_err_n = parity_error_n_o;
    nxt_hold_cnt = hold_cnt_ff;
    if (hold_cnt_ff != 2'b00) begin
      nxt_hold_cnt = hold_cnt_ff - 2'b01;
      nxt_err_n = 1'b0;
      if (!gate_stage_ff) begin
        nxt_ppo = odd_stage_ff;
      end
    end else if (!gate_stage_ff) begin
      nxt_ppo = odd_stage_ff;
      nxt_err_n = ~odd_stage_ff;
      nxt_hold_cnt = odd_stage_ff ? HOLD_LAST : 2'b00;
    end
  end

  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      partial_parity_out_o <= `RBPC_OUT_RST;
      parity_error_n_o <= `RBPC_ERR_N_RST;
      parity_error_oe_o <= 1'b0;
      hold_cnt_ff <= 2'b00;
    end else begin
      partial_parity_out_o <= nxt_ppo;
      parity_error_n_o <= nxt_err_n;
      parity_error_oe_o <= ~nxt_err_n;
      hold_cnt_ff <= nxt_hold_cnt;
    end
  end

  // Data path: captured words pass the buffer; a stalled load loses nothing until BUF_DEPTH words wait, then further words are dropped.
  wire [BW-1:0] buf_in_word;
  wire [BW-1:0] buf_out_word;
  wire buf_in_ready;
  wire buf_out_valid;
  wire buf_full;
  wire buf_empty;
  wire pop;

  assign buf_in_word = {cap_gate, cap_odt, cap_cke, cap_cs_n, cap_data};
  assign pop = buf_out_valid & out_ready_i;

  rbpc_buf2 #(
    .W(BW),
    .DEPTH(BUF_DEPTH),
    .AW(1)
  ) u_buf (
    .clk_i(core_clk_i),
    .rst_i(sys_rst_i),
    .in_valid_i(cap_valid),
    .in_ready_o(buf_in_ready),
    .in_data_i(buf_in_word),
    .out_valid_o(buf_out_valid),
    .out_ready_i(out_ready_i),
    .out_data_o(buf_out_word),
    .full_o(buf_full),
    .empty_o(buf_empty)
  );

  wire [DW-1:0] drn_data;
  wire drn_cs_n;
  wire drn_cke;
  wire drn_odt;
  wire drn_gate;
  wire [DW-1:0] wide_image;
  wire [NW-1:0] narrow_image;

  assign drn_data = buf_out_word[DW-1:0];
  assign drn_cs_n = buf_out_word[DW];
  assign drn_cke = buf_out_word[DW+1];
  assign drn_odt = buf_out_word[DW+2];
  assign drn_gate = buf_out_word[DW+3];

  // Narrow mode drives only the low bits; unused wide bits sit low.
  genvar g;
  generate
    for (g = 0; g < DW; g = g + 1) begin : g_wide
      if (g < NW) begin : g_low
        assign wide_image[g] = drn_data[g];
        assign narrow_image[g] = drn_data[g];
      end else begin : g_high
        assign wide_image[g] = cap_width ? 1'b0 : drn_data[g];
      end
    end
  endgenerate

  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_out_o <= {DW{`RBPC_OUT_RST}};
      data_out_b_o <= {NW{`RBPC_OUT_RST}};
      chip_select_out_n_o <= `RBPC_OUT_RST;
      chip_select_out_b_n_o <= `RBPC_OUT_RST;
      clk_enable_out_o <= `RBPC_OUT_RST;
      clk_enable_out_b_o <= `RBPC_OUT_RST;
      termination_out_o <= `RBPC_OUT_RST;
      termination_out_b_o <= `RBPC_OUT_RST;
      out_valid_o <= 1'b0;
      in_ready_o <= 1'b0;
    end else begin
      out_valid_o <= pop;
      in_ready_o <= buf_in_ready & ~buf_full;
      if (pop) begin
        // Module-dependent copies move with every word, gated or not.
        chip_select_out_n_o <= drn_cs_n;
        clk_enable_out_o <= drn_cke;
        termination_out_o <= drn_odt;
        chip_select_out_b_n_o <= cap_width & drn_cs_n;
        clk_enable_out_b_o <= cap_width & drn_cke;
        termination_out_b_o <= cap_width & drn_odt;
        if (!drn_gate) begin
          data_out_o <= wide_image;
          data_out_b_o <= cap_width ? narrow_image : {NW{1'b0}};
        end
      end
    end
  end
  // Data and control copy outputs hold between edges and between drained words; out_valid_o and in_ready_o update every cycle.

  // The empty flag is not read anywhere; it only drives the unused_empty wire.
  wire unused_empty;
  assign unused_empty = buf_empty;
endmodule

// >>> rbpc_top_asserts.sv
// Checker of output update timing, parity flag and reset values.
// Assumes it is bound to rbpc_top and sees only its ports.
`timescale 1ns/1ps
module rbpc_chk #(
  parameter DW = 25,
  parameter NW = 14
) (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire config_sel_width_i,
  input wire [DW-1:0] data_out_o,
  input wire [NW-1:0] data_out_b_o,
  input wire partial_parity_out_o,
  input wire parity_error_n_o,
  input wire parity_error_oe_o,
  input wire chip_select_out_n_o,
  input wire chip_select_out_b_n_o,
  input wire clk_enable_out_o,
  input wire clk_enable_out_b_o,
  input wire termination_out_o,
  input wire termination_out_b_o,
  input wire out_valid_o
);
  default clocking @(posedge core_clk_i); endclocking
  property p_rst;
    sys_rst_i && $past(sys_rst_i) |-> data_out_o == 0 && data_out_b_o == 0
      && !partial_parity_out_o && parity_error_n_o && !out_valid_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_oe;
    disable iff (sys_rst_i) parity_error_oe_o == !parity_error_n_o;
  endproperty
  a_oe: assert property (p_oe) else $error("error enable not inverse");
  property p_hold;
    disable iff (sys_rst_i) $fell(parity_error_n_o) |=> !parity_error_n_o;
  endproperty
  a_hold: assert property (p_hold) else $error("error flag not held");
  property p_ppo;
    disable iff (sys_rst_i) $rose(partial_parity_out_o) |-> !parity_error_n_o;
  endproperty
  a_ppo: assert property (p_ppo) else $error("odd result without error");
  property p_even;
    disable iff (sys_rst_i) $rose(parity_error_n_o) |-> !partial_parity_out_o;
  endproperty
  a_even: assert property (p_even) else $error("error cleared on odd");
  property p_upd;
    disable iff (sys_rst_i) $changed(data_out_o) |-> out_valid_o;
  endproperty
  a_upd: assert property (p_upd) else $error("data changed without word");
  property p_narrow;
    disable iff (sys_rst_i) out_valid_o && config_sel_width_i && $past(config_sel_width_i, 8)
      |-> data_out_b_o == data_out_o[NW-1:0] && data_out_o[DW-1:NW] == 0;
  endproperty
  a_narrow: assert property (p_narrow) else $error("copies differ");
  property p_copy;
    disable iff (sys_rst_i) out_valid_o && config_sel_width_i && $past(config_sel_width_i, 8)
      |-> chip_select_out_b_n_o == chip_select_out_n_o && clk_enable_out_b_o == clk_enable_out_o
      && termination_out_b_o == termination_out_o;
  endproperty
  a_copy: assert property (p_copy) else $error("control copies differ");
  property p_wide;
    disable iff (sys_rst_i) out_valid_o && !config_sel_width_i
      && !$past(config_sel_width_i, 8) |-> data_out_b_o == 0;
  endproperty
  a_wide: assert property (p_wide) else $error("second copy driven");
  property p_rel;
    disable iff (sys_rst_i) $fell(sys_rst_i) |-> data_out_o == 0 ##1 data_out_o == 0;
  endproperty
  a_rel: assert property (p_rel) else $error("output moved at release");
endmodule
bind rbpc_top rbpc_chk #(.DW(DW), .NW(NW)) chk_u (
  .core_clk_i(core_clk_i),
  .sys_rst_i(sys_rst_i),
  .config_sel_width_i(config_sel_width_i),
  .data_out_o(data_out_o),
  .data_out_b_o(data_out_b_o),
  .partial_parity_out_o(partial_parity_out_o),
  .parity_error_n_o(parity_error_n_o),
  .parity_error_oe_o(parity_error_oe_o),
  .chip_select_out_n_o(chip_select_out_n_o),
  .chip_select_out_b_n_o(chip_select_out_b_n_o),
  .clk_enable_out_o(clk_enable_out_o),
  .clk_enable_out_b_o(clk_enable_out_b_o),
  .termination_out_o(termination_out_o),
  .termination_out_b_o(termination_out_b_o),
  .out_valid_o(out_valid_o)
);

// >>> rbpc_ctrl_model.sv
// Controller model: one word per request, parity one or two cycles behind.
// Assumes requests are raised at the rising edge.
`timescale 1ns/1ps
module rbpc_ctrl_model (
  input wire clk_i,
  input wire rst_i,
  input wire req_i,
  input wire [24:0] word_i,
  input wire [3:0] ctl_i,
  input wire [24:0] mask_i,
  input wire flip_i,
  input wire lag2_i,
  output reg [24:0] data_o,
  output reg [3:0] ctl_o,
  output reg valid_o,
  output reg parity_o
);
  reg [1:0] par_ff;
  always @(posedge clk_i) begin
    if (rst_i) begin
      data_o <= 25'h000_0000;
      ctl_o <= 4'hc;
      valid_o <= 1'b0;
      parity_o <= 1'b0;
      par_ff <= 2'b00;
    end else begin
      // Idle cycles deselect and invert data_o each cycle, so the stale word returns every second idle cycle.
      data_o <= req_i ? word_i : ~data_o;
      ctl_o <= req_i ? ctl_i : 4'hc;
      valid_o <= req_i;
      par_ff <= {par_ff[0], ^(word_i & mask_i) ^ flip_i};
      parity_o <= lag2_i ? par_ff[1] : par_ff[0];
    end
  end
endmodule

// >>> tb_rbpc_top.sv
// Testbench of rbpc_top: random words in three modes, parity faults, gating, stall.
// Assumes the controller model feeds the pins and the bench drains the outputs.
`timescale 1ns/1ps
module tb_rbpc_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg ab = 1'b0;
  reg wd = 1'b0;
  reg req = 1'b0;
  reg flip = 1'b0;
  reg rdy = 1'b1;
  reg [24:0] word = 25'h000_0000;
  reg [3:0] ctl = 4'hc;
  reg [31:0] seed = 32'h914d_85a8;
  reg [24:0] last = 25'h000_0000;
  wire [24:0] d_in, q;
  wire [3:0] c_in;
  wire v_in, p_in, cs_q, cke_q, odt_q, partial_parity_out, err_n, irdy, ovld;
  integer failures = 0;
  integer total_checks = 0;
  integer m, i;
  logic [27:0] exq[$];
  always #2 clk = ~clk;
  rbpc_ctrl_model ctrl_u (.clk_i(clk), .rst_i(rst), .req_i(req), .word_i(word),
    .ctl_i(ctl), .mask_i(mask_of(ab, wd)), .flip_i(flip), .lag2_i(ab),
    .data_o(d_in), .ctl_o(c_in), .valid_o(v_in), .parity_o(p_in));
  rbpc_top dut_u (.core_clk_i(clk), .sys_rst_i(rst), .config_sel_ab_i(ab),
    .config_sel_width_i(wd), .data_in_i(d_in), .dimm_chip_select_n_i(c_in[3]),
    .chip_select_aux_n_i(c_in[2]), .clk_enable_in_i(c_in[1]), .termination_in_i(c_in[0]),
    .parity_in_i(p_in), .in_valid_i(v_in), .out_ready_i(rdy), .data_out_o(q),
    .data_out_b_o(), .chip_select_out_n_o(cs_q), .chip_select_out_b_n_o(),
    .clk_enable_out_o(cke_q), .clk_enable_out_b_o(), .termination_out_o(odt_q),
    .termination_out_b_o(), .partial_parity_out_o(partial_parity_out), .parity_error_n_o(err_n),
    .parity_error_oe_o(), .in_ready_o(irdy), .out_valid_o(ovld));
  function automatic [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic [24:0] mask_of(input a, input w);
    mask_of = !w ? 25'h1ff_ffb6 : (a ? 25'h000_1bbf : 25'h000_3fb6);
  endfunction
  function automatic [24:0] word_of(input [31:0] s);
    word_of = wd ? {11'h000, s[13:0]} : s[24:0];
  endfunction
  task chk_word(input logic [27:0] got, input logic [27:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task send(input [24:0] w, input [3:0] c, input f);
    req <= 1'b1;
    word <= w;
    ctl <= c;
    flip <= f;
    if (!(c[3] & c[2])) last = w;
    exq.push_back({c[3], c[1], c[0], last});
    @(posedge clk);
  endtask
  task idle(input integer n);
    req <= 1'b0;
    flip <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task wait_err(input logic e);
    #1;
    repeat (16) if (err_n !== e) begin
      @(posedge clk);
      #1;
    end
    chk_bit(err_n, e);
    chk_bit(partial_parity_out, !e);
    @(posedge clk);
  endtask
  task end_of_test;
    if (failures == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(negedge clk) if (!rst && ovld === 1'b1) chk_word({cs_q, cke_q, odt_q, q}, exq.pop_front());
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    end_of_test;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (m = 0; m < 3; m++) begin
      ab <= (m == 2);
      wd <= (m != 0);
      idle(8);
      for (i = 0; i < 16; i++) begin
        seed = lfsr(seed);
        send(word_of(seed), {seed[31], seed[30] & ~seed[31], seed[27:26]}, 1'b0);
      end
      idle(10);
      wait_err(1'b1);
      send(word_of(seed), 4'h1, 1'b1);
      idle(1);
      wait_err(1'b0);
      send(word_of(lfsr(seed)), 4'h2, 1'b0);
      idle(1);
      wait_err(1'b1);
      send(word_of(seed), 4'hc, 1'b1);
      idle(1);
      repeat (10) begin
        #1;
        chk_bit(err_n, 1'b1);
        @(posedge clk);
      end
      wait_err(1'b1);
    end
    rdy <= 1'b0;
    for (i = 0; i < 4; i++) if (irdy === 1'b1) begin
      send(word_of(seed), 4'h0, 1'b0);
      idle(6);
    end
    @(negedge clk);
    chk_bit(irdy, 1'b0);
    @(posedge clk);
    rdy <= 1'b1;
    idle(8);
    chk_bit(exq.size() == 0, 1'b1);
    rst <= 1'b1;
    #1;
    chk_word({cs_q, cke_q, odt_q, q}, 28'h000_0000);
    chk_bit(err_n, 1'b1);
    @(posedge clk);
    idle(3);
    rst <= 1'b0;
    idle(4);
    end_of_test;
  end
endmodule
